// *** cep_pkg.sv ***
// Package for the core exception prioritizer: cause ranks, codes and states
package cep_pkg;
    // Number of exception causes, index 0 is highest rank
    localparam int CEP_NUM = 21;
    localparam int CEP_IDX_W = 5;
    typedef logic [CEP_IDX_W-1:0] cep_idx_t;
    // Cause ranks, highest first
    localparam cep_idx_t CEP_RESET = 5'h00;
    localparam cep_idx_t CEP_DSTEP = 5'h01;
    localparam cep_idx_t CEP_DEBUG_INT_EXC = 5'h02;
    localparam cep_idx_t CEP_NMI = 5'h03;
    localparam cep_idx_t CEP_INT = 5'h04;
    localparam cep_idx_t CEP_IBRK = 5'h05;
    localparam cep_idx_t CEP_FADR = 5'h06;
    localparam cep_idx_t CEP_FBUS = 5'h07;
    localparam cep_idx_t CEP_SWDBG = 5'h08;
    localparam cep_idx_t CEP_SYS = 5'h09;
    localparam cep_idx_t CEP_BRK = 5'h0A;
    localparam cep_idx_t CEP_RSVD = 5'h0B;
    localparam cep_idx_t CEP_CPU = 5'h0C;
    localparam cep_idx_t CEP_EXTD = 5'h0D;
    localparam cep_idx_t CEP_OVF = 5'h0E;
    localparam cep_idx_t CEP_TRAP = 5'h0F;
    localparam cep_idx_t CEP_DBRK = 5'h10;
    localparam cep_idx_t CEP_LADR = 5'h11;
    localparam cep_idx_t CEP_SADR = 5'h12;
    localparam cep_idx_t CEP_DBUS = 5'h13;
    localparam cep_idx_t CEP_LDBRK = 5'h14;
    localparam cep_idx_t CEP_NONE = 5'h1F;
    // Causes that are debug exceptions
    localparam logic [CEP_NUM-1:0] CEP_DEBUG_MASK = 21'h110126;
    localparam logic [CEP_NUM-1:0] CEP_ZERO = 21'h000000;
    typedef enum logic [1:0] {
        CEP_ST_NORMAL,
        CEP_ST_DEBUG
    } cep_state_e;
endpackage : cep_pkg

// *** cep_pick.sv ***
// Fixed-priority picker: lowest index among pending causes wins
`timescale 1ns/1ps
module cep_pick
    import cep_pkg::*;
(
    input wire logic [CEP_NUM-1:0] req_in,
    output logic found_out,
    output cep_idx_t idx_out,
    output logic [CEP_NUM-1:0] onehot_out
);
    always_comb begin
        found_out = 1'b0;
        idx_out = CEP_NONE;
        onehot_out = CEP_ZERO;
        for (int i = CEP_NUM - 1; i >= 0; i--) begin
            if (req_in[i]) begin
                found_out = 1'b1;
                idx_out = cep_idx_t'(i);
                onehot_out = CEP_ZERO;
                onehot_out[i] = 1'b1;
            end
        end
    end
endmodule : cep_pick

// *** cep_core_exception_prioritizer.sv ***
// Exception identification, prioritisation and debug mode tracking
`timescale 1ns/1ps
module cep_core_exception_prioritizer
    import cep_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic master_clear_pin_in,
    input wire logic por_in,
    input wire logic debug_step_in,
    input wire logic ext_debug_int_input_in,
    input wire logic debug_break_request_bit_in,
    input wire logic nmi_in,
    input wire logic [7:0] int_req_in,
    input wire logic [7:0] int_mask_in,
    input wire logic global_int_en_in,
    input wire logic instr_break_match_in,
    input wire logic fetch_misaligned_in,
    input wire logic fetch_protected_in,
    input wire logic fetch_bus_err_in,
    input wire logic debug_breakpoint_instr_in,
    input wire logic service_call_instr_in,
    input wire logic break_instr_in,
    input wire logic reserved_opcode_in,
    input wire logic cop_instr_in,
    input wire logic cop_enabled_in,
    input wire logic ext_instr_in,
    input wire logic ext_enabled_in,
    input wire logic trap_arith_in,
    input wire logic arith_overflow_in,
    input wire logic trap_instr_in,
    input wire logic trap_cond_in,
    input wire logic data_addr_break_in,
    input wire logic store_in,
    input wire logic store_value_break_in,
    input wire logic load_in,
    input wire logic data_misaligned_in,
    input wire logic data_protected_in,
    input wire logic data_bus_err_in,
    input wire logic load_data_break_in,
    input wire logic debug_return_instr_in,
    output logic exc_take_out,
    output logic [CEP_IDX_W-1:0] exc_code_out,
    output logic [CEP_NUM-1:0] exc_onehot_out,
    output logic [CEP_NUM-1:0] exc_deferred_out,
    output logic debug_exc_out,
    output logic core_reset_out,
    output logic debug_mode_out
);
    logic [CEP_NUM-1:0] cause;
    logic [CEP_NUM-1:0] onehot;
    logic found;
    cep_idx_t idx;
    logic in_debug;
    logic dbg_taken;
    cep_state_e state_r;
    cep_state_e state_nxt;
    logic take_r;
    cep_idx_t code_r;
    logic [CEP_NUM-1:0] onehot_r;
    logic [CEP_NUM-1:0] defer_r;
    logic dbg_exc_r;
    logic reset_r;

    assign in_debug = (state_r == CEP_ST_DEBUG);

    // Collect causes, one bit per rank
    always_comb begin
        cause = CEP_ZERO;
        cause[CEP_RESET] = master_clear_pin_in | por_in;
        cause[CEP_DSTEP] = debug_step_in & ~in_debug;
        cause[CEP_DEBUG_INT_EXC] = (ext_debug_int_input_in | debug_break_request_bit_in)
            & ~in_debug;
        cause[CEP_NMI] = nmi_in;
        // Maskable interrupts (not NMI) are held off while the debug handler runs
        cause[CEP_INT] = (|(int_req_in & ~int_mask_in)) & global_int_en_in
            & ~in_debug;
        cause[CEP_IBRK] = instr_break_match_in & ~in_debug;
        cause[CEP_FADR] = fetch_misaligned_in | fetch_protected_in;
        cause[CEP_FBUS] = fetch_bus_err_in;
        cause[CEP_SWDBG] = debug_breakpoint_instr_in;
        cause[CEP_SYS] = service_call_instr_in;
        cause[CEP_BRK] = break_instr_in;
        cause[CEP_RSVD] = reserved_opcode_in;
        cause[CEP_CPU] = cop_instr_in & ~cop_enabled_in;
        cause[CEP_EXTD] = ext_instr_in & ~ext_enabled_in;
        cause[CEP_OVF] = trap_arith_in & arith_overflow_in;
        cause[CEP_TRAP] = trap_instr_in & trap_cond_in;
        cause[CEP_DBRK] = (data_addr_break_in | (store_in & store_value_break_in))
            & ~in_debug;
        cause[CEP_LADR] = load_in & (data_misaligned_in | data_protected_in);
        cause[CEP_SADR] = store_in & (data_misaligned_in | data_protected_in);
        cause[CEP_DBUS] = (load_in | store_in) & data_bus_err_in;
        cause[CEP_LDBRK] = load_in & load_data_break_in & ~in_debug;
    end

    cep_pick u_pick (
        .req_in(cause),
        .found_out(found),
        .idx_out(idx),
        .onehot_out(onehot)
    );

    assign dbg_taken = |(onehot & CEP_DEBUG_MASK);

    // Debug mode state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            CEP_ST_NORMAL: begin
                if (dbg_taken) begin
                    state_nxt = CEP_ST_DEBUG;
                end
            end
            CEP_ST_DEBUG: begin
                if (debug_return_instr_in && !found) begin
                    state_nxt = CEP_ST_NORMAL;
                end
            end
            default: begin
                state_nxt = CEP_ST_NORMAL;
            end
        endcase
        if (onehot[CEP_RESET]) begin
            state_nxt = CEP_ST_NORMAL;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_r <= CEP_ST_NORMAL;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Registered selection of the single winning cause
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            take_r <= 1'b0;
            code_r <= CEP_NONE;
            onehot_r <= CEP_ZERO;
            defer_r <= CEP_ZERO;
            dbg_exc_r <= 1'b0;
            reset_r <= 1'b0;
        end else begin
            take_r <= found;
            code_r <= idx;
            onehot_r <= onehot;
            defer_r <= cause & ~onehot;
            dbg_exc_r <= dbg_taken;
            reset_r <= onehot[CEP_RESET];
        end
    end

    assign exc_take_out = take_r;
    assign exc_code_out = code_r;
    assign exc_onehot_out = onehot_r;
    assign exc_deferred_out = defer_r;
    assign debug_exc_out = dbg_exc_r;
    assign core_reset_out = reset_r;
    assign debug_mode_out = in_debug;
endmodule : cep_core_exception_prioritizer

// *** cep_prio_checker.sv ***
// Concurrent checks on the exception prioritizer ports
`timescale 1ns/1ps
module cep_prio_checker
    import cep_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic master_clear_pin_in,
    input wire logic por_in,
    input wire logic debug_step_in,
    input wire logic ext_debug_int_input_in,
    input wire logic debug_break_request_bit_in,
    input wire logic exc_take_out,
    input wire logic [CEP_IDX_W-1:0] exc_code_out,
    input wire logic [CEP_NUM-1:0] exc_onehot_out,
    input wire logic [CEP_NUM-1:0] exc_deferred_out,
    input wire logic debug_exc_out,
    input wire logic core_reset_out,
    input wire logic debug_mode_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);
    sequence rst_cause; master_clear_pin_in || por_in; endsequence
    sequence dbg_free; !debug_mode_out && !master_clear_pin_in && !por_in; endsequence
    reset_wins_a: assert property (rst_cause |=> core_reset_out && exc_code_out == CEP_RESET)
        else $error("reset not taken first");
    step_second_a: assert property (dbg_free ##0 debug_step_in |=> exc_code_out == CEP_DSTEP)
        else $error("single step not second");
    debug_int_a: assert property (dbg_free ##0 (!debug_step_in && (ext_debug_int_input_in ||
        debug_break_request_bit_in)) |=> exc_code_out == CEP_DEBUG_INT_EXC && debug_mode_out)
        else $error("debug interrupt not taken");
    winner_onehot_a: assert property (exc_take_out |-> $onehot(exc_onehot_out)
        && exc_onehot_out[exc_code_out]) else $error("winner one-hot wrong");
    lower_only_a: assert property (exc_take_out |->
        (exc_deferred_out << (CEP_NUM - 1 - exc_code_out)) == CEP_ZERO) else $error("bad deferral");
    class_flags_a: assert property (exc_take_out |-> debug_exc_out ==
        CEP_DEBUG_MASK[exc_code_out] && core_reset_out == (exc_code_out == CEP_RESET))
        else $error("class flags wrong");
    debug_enter_a: assert property (exc_take_out && debug_exc_out |-> debug_mode_out)
        else $error("debug mode not entered");
    lowest_load_a: assert property (exc_code_out == CEP_LDBRK |-> exc_deferred_out == CEP_ZERO)
        else $error("cause below load break");
endmodule : cep_prio_checker
bind cep_core_exception_prioritizer cep_prio_checker cep_prio_checker_inst (.*);

// *** cep_irq_model.sv ***
// Interrupt controller model behind the request pins
`timescale 1ns/1ps
module cep_irq_model (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic [7:0] raise_in,
    input wire logic [7:0] block_in,
    output logic [7:0] int_req_out,
    output logic [7:0] int_mask_out,
    output logic int_en_out
);
    assign int_req_out = raise_in;
    assign int_mask_out = block_in;
    // Global enable comes up once out of reset
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            int_en_out <= 1'b0;
        end else begin
            int_en_out <= 1'b1;
        end
    end
endmodule : cep_irq_model

// *** cep_core_exception_prioritizer_tb_top.sv ***
// Self-checking bench for the core exception prioritizer
`timescale 1ns/1ps
`define CHK(n, e, a) \
    samples_checked++; \
    if ((a) !== (e)) begin \
        error_cnt++; \
        $display("BAD %s exp %0h got %0h", n, e, a); \
    end
module cep_core_exception_prioritizer_tb_top
    import cep_pkg::*;
();
    logic clk_sys_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [CEP_NUM-1:0] cv = CEP_ZERO;
    logic [13:0] ax = 14'h0000;
    logic [7:0] blk = 8'h00;
    int error_cnt = 0;
    int samples_checked = 0;
    logic exc_take_out, debug_exc_out, core_reset_out, debug_mode_out, global_int_en_in;
    logic [7:0] int_req_in, int_mask_in;
    logic [CEP_IDX_W-1:0] exc_code_out;
    logic [CEP_NUM-1:0] exc_onehot_out, exc_deferred_out;
    cep_irq_model cep_irq_model_inst (.clk_sys_in, .rstn_in, .raise_in({7'h00, cv[4]}),
        .block_in(blk), .int_req_out(int_req_in), .int_mask_out(int_mask_in),
        .int_en_out(global_int_en_in));
    cep_core_exception_prioritizer cep_core_exception_prioritizer_inst (.*,
        .master_clear_pin_in(cv[0]), .debug_step_in(cv[1]), .ext_debug_int_input_in(cv[2]),
        .nmi_in(cv[3]), .instr_break_match_in(cv[5]), .fetch_misaligned_in(cv[6]),
        .fetch_bus_err_in(cv[7]), .debug_breakpoint_instr_in(cv[8]), .service_call_instr_in(cv[9]),
        .break_instr_in(cv[10]), .reserved_opcode_in(cv[11]), .cop_instr_in(cv[12]),
        .ext_instr_in(cv[13]), .trap_arith_in(cv[14]), .trap_instr_in(cv[15]),
        .data_addr_break_in(cv[16]), .data_misaligned_in(cv[17]), .por_in(ax[0]),
        .debug_break_request_bit_in(ax[1]), .fetch_protected_in(ax[2]), .cop_enabled_in(ax[3]),
        .ext_enabled_in(ax[4]), .arith_overflow_in(ax[5]), .trap_cond_in(ax[6]),
        .store_in(ax[7]), .store_value_break_in(ax[8]), .load_in(ax[9]),
        .data_protected_in(ax[10]), .data_bus_err_in(ax[11]), .load_data_break_in(ax[12]),
        .debug_return_instr_in(ax[13]));
    task automatic test_done();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done
    // Inputs change at an edge; outputs judged after the next edge only
    task automatic drive(input logic [CEP_NUM-1:0] c, input logic [13:0] a, input logic [7:0] m = 8'h00);
        @(posedge clk_sys_in);
        cv <= c;
        ax <= a;
        blk <= m;
        @(posedge clk_sys_in);
        #1;
    endtask : drive
    task automatic debug_flow();
        drive(21'h000010, 14'h0000, 8'h01);
        `CHK("masked", 1'b0, exc_take_out)
        drive(21'h000002, 14'h0000);
        `CHK("step", 1'b1, debug_mode_out)
        drive(21'h000010, 14'h0002);
        `CHK("refused", 1'b0, exc_take_out)
        drive(CEP_ZERO, 14'h2000);
        drive(CEP_ZERO, 14'h0002);
        `CHK("brkreq", CEP_DEBUG_INT_EXC, exc_code_out)
        drive(CEP_ZERO, 14'h2000);
    endtask : debug_flow
    // Each cause of rank 0 to 16 raised with the next lower one
    task automatic rank_pairs();
        for (int r = 0; r < 17; r++) begin
            drive(21'h000003 << r, 14'h0260);
            `CHK("win", r[4:0], exc_code_out)
            `CHK("def", 1'b1, exc_deferred_out[r+1])
            drive(CEP_ZERO, 14'h2260);
            drive(CEP_ZERO, 14'h0260);
            `CHK("normal", 1'b0, debug_mode_out)
        end
    endtask : rank_pairs
    task automatic data_ranks();
        drive(CEP_ZERO, 14'h1A00);
        `CHK("bus", CEP_DBUS, exc_code_out)
        drive(CEP_ZERO, 14'h1200);
        `CHK("ldbrk", CEP_LDBRK, exc_code_out)
        drive(CEP_ZERO, 14'h0C80);
        `CHK("stadr", CEP_SADR, exc_code_out)
        `CHK("busdef", 1'b1, exc_deferred_out[CEP_DBUS])
        drive(CEP_ZERO, 14'h0001);
        `CHK("por", 1'b1, core_reset_out)
        `CHK("porexit", 1'b0, debug_mode_out)
        drive(CEP_ZERO, 14'h0D80);
        `CHK("stbrk", CEP_DBRK, exc_code_out)
        `CHK("sadef", 1'b1, exc_deferred_out[CEP_SADR])
    endtask : data_ranks
    initial begin
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end
    initial begin
        repeat (5) @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        debug_flow();
        rank_pairs();
        data_ranks();
        test_done();
    end
    initial begin
        repeat (5000) @(posedge clk_sys_in);
        error_cnt++;
        test_done();
    end
endmodule : cep_core_exception_prioritizer_tb_top
